// ===== hw/dacc_defs.vh
`ifndef DACC_DEFS_VH
`define DACC_DEFS_VH
// core control register field positions
`define DACC_MUL_FMT_BIT 0
`define DACC_GUARD_EN_BIT 4
// multiply format values
`define DACC_FMT_FRACT 1'b0
`define DACC_FMT_INT 1'b1
// accumulator geometry
`define DACC_ACC_W 40
`define DACC_WORD_W 16
`define DACC_GUARD_W 8
`define DACC_LOW_LSB 0
`define DACC_LOW_MSB 15
`define DACC_HIGH_LSB 16
`define DACC_HIGH_MSB 31
`define DACC_GUARD_LSB 32
`define DACC_GUARD_MSB 39
`define DACC_SIGN32 31
// saturation limits
`define DACC_POS32 40'h007FFFFFFF
`define DACC_NEG32 40'hFF80000000
// register select codes for the six accumulator words
`define DACC_SEL_A_LOW 3'h0
`define DACC_SEL_A_HIGH 3'h1
`define DACC_SEL_A_UPPER 3'h2
`define DACC_SEL_B_LOW 3'h3
`define DACC_SEL_B_HIGH 3'h4
`define DACC_SEL_B_UPPER 3'h5
// operation codes
`define DACC_OP_NONE 2'h0
`define DACC_OP_LOAD 2'h1
`define DACC_OP_MPY 2'h2
`define DACC_OP_ADD 2'h3
// reset value of accumulators
`define DACC_ACC_RESET 40'h0000000000
`define DACC_WORD_RESET 16'h0000
`endif

// ===== hw/dacc_result_fmt.v
`timescale 1ns/10ps
`include "dacc_defs.vh"
// forms the value written back into an accumulator: wide or saturated
module dacc_result_fmt #(
  parameter ACC_W = `DACC_ACC_W
) (
  input wire [ACC_W-1:0] value_in,
  input wire guard_en_in,
  output reg [ACC_W-1:0] result_out
);
  wire fits32;
  // value fits 1.31 when bits above bit 31 all copy the sign
  assign fits32 = (&value_in[ACC_W-1:`DACC_SIGN32]) | ~(|value_in[ACC_W-1:`DACC_SIGN32]);

  // guard mode keeps the full 9.31 word, normal mode clamps to 1.31
  always @* begin
    if (guard_en_in) begin
      result_out = value_in; // [RULE5] [RULE6] [RULE7] [RULE15]
    end else if (fits32) begin
      result_out = value_in; // [RULE3] [RULE4]
    end else if (value_in[ACC_W-1]) begin
      result_out = `DACC_NEG32; // [RULE20]
    end else begin
      result_out = `DACC_POS32; // [RULE20]
    end
  end
endmodule

// ===== hw/dacc_datapath.v
`timescale 1ns/10ps
`include "dacc_defs.vh"
// Contract
// [RULE1] integers are 16-bit signed two's complement
// [RULE2] fractions are 1.15, point after sign
// [RULE3] normal mode holds 1.31 in low 32
// [RULE4] normal mode: upper byte only sign-extends
// [RULE5] guard enable widens accumulators to 40 bits
// [RULE6] guard mode spans full signed 40 bits
// [RULE7] guard fractions are 9.31, point fixed
// [RULE8] non-multiply ops identical for both formats
// [RULE9] format bit: 0 fractional, 1 integer
// [RULE10] integer multiply gives unshifted 32-bit product
// [RULE11] fractional product shifted left one bit
// [RULE12] accumulator is upper, high, low concatenated
// [RULE13] load: high word, low zero, sign upper
// [RULE14] rounded store takes the high word; the store here takes the high word unrounded
// [RULE15] guard mode writes all three parts
// [RULE16] six sub-registers readable and writable
// [RULE17] upper registers read sign-extended to 16
// [RULE18] software should prefer load/store operations
// [RULE19] fraction spans -1.0 to 0x7FFF
// [RULE20] normal mode clamps outside 32-bit range
module dacc_datapath #(
  parameter WORD_W = `DACC_WORD_W,
  parameter ACC_W = `DACC_ACC_W
) (
  input wire clock_in,
  input wire reset_in,
  input wire [WORD_W-1:0] core_control_reg_in,
  input wire [1:0] op_in,
  input wire op_acc_sel_in,
  input wire [WORD_W-1:0] op_a_in,
  input wire [WORD_W-1:0] op_b_in,
  input wire store_in,
  input wire store_acc_sel_in,
  input wire reg_wr_in,
  input wire [2:0] reg_sel_in,
  input wire [WORD_W-1:0] reg_wdata_in,
  output reg [WORD_W-1:0] reg_rdata_out,
  output reg [WORD_W-1:0] store_data_out,
  output reg store_valid_out,
  output reg guard_mode_out
);
  // accumulator state and its next value
  reg [ACC_W-1:0] acc_one_reg;
  reg [ACC_W-1:0] acc_two_reg;
  reg [ACC_W-1:0] acc_one_next;
  reg [ACC_W-1:0] acc_two_next;
  // next values of the registered outputs
  reg [WORD_W-1:0] rdata_next;
  reg [WORD_W-1:0] store_data_next;
  wire store_valid_next;
  wire guard_mode_next;
  // operation path
  reg [ACC_W-1:0] cur_acc;
  reg [ACC_W-1:0] raw_value;
  wire [ACC_W-1:0] fmt_value;
  wire guard_en;
  wire int_mode;
  wire op_active;
  wire op_to_one;
  wire op_to_two;
  // multiplier
  wire signed [WORD_W-1:0] mul_a;
  wire signed [WORD_W-1:0] mul_b;
  wire signed [2*WORD_W-1:0] product;
  wire [2*WORD_W-1:0] product_shifted;
  wire [2*WORD_W-1:0] aligned;
  wire [`DACC_GUARD_W-1:0] product_sign;
  wire [ACC_W-1:0] product_ext;
  // load and add
  wire [`DACC_GUARD_W-1:0] op_a_sign;
  wire [ACC_W-1:0] load_ext;
  wire [ACC_W-1:0] add_ext;
  // register write decode
  wire wr_one_low;
  wire wr_one_high;
  wire wr_one_upper;
  wire wr_two_low;
  wire wr_two_high;
  wire wr_two_upper;
  // per-part next values
  reg [WORD_W-1:0] one_low_next;
  reg [WORD_W-1:0] one_high_next;
  reg [`DACC_GUARD_W-1:0] one_guard_next;
  reg [WORD_W-1:0] two_low_next;
  reg [WORD_W-1:0] two_high_next;
  reg [`DACC_GUARD_W-1:0] two_guard_next;
  // stored signs and the sign-extended guard byte views
  wire one_sign;
  wire two_sign;
  wire [WORD_W-1:0] one_upper_view;
  wire [WORD_W-1:0] two_upper_view;

  // control bits from the core control register
  assign guard_en = core_control_reg_in[`DACC_GUARD_EN_BIT]; // [RULE5]
  assign int_mode = (core_control_reg_in[`DACC_MUL_FMT_BIT] == `DACC_FMT_INT); // [RULE9]

  // operation decode: a non-idle code lands in the selected accumulator
  assign op_active = (op_in != `DACC_OP_NONE);
  assign op_to_one = op_active & ~op_acc_sel_in;
  assign op_to_two = op_active & op_acc_sel_in;

  // operands are signed; 0x8000 is -32768 or -1.0 depending on reading
  assign mul_a = op_a_in; // [RULE1] [RULE2] [RULE19]
  assign mul_b = op_b_in; // [RULE1] [RULE2] [RULE19]
  assign product = mul_a * mul_b;
  // fractional 2.30 product moves up one place to sit at the 1.31 point
  assign product_shifted = {product[2*WORD_W-2:0], 1'h0}; // [RULE11]
  // the shift drops the top bit, costing one bit of range; -1.0 times -1.0 wraps to -1.0
  assign aligned = int_mode ? product : product_shifted; // [RULE10] [RULE11]
  // a 16x16 product always fits 32 bits, so the guard byte is pure sign
  assign product_sign = {`DACC_GUARD_W{aligned[2*WORD_W-1]}};
  assign product_ext = {product_sign, aligned};

  // operand sign, copied into the guard byte on load and add
  assign op_a_sign = {`DACC_GUARD_W{op_a_in[WORD_W-1]}};
  // load fills high word, zeroes low word, sign into guard byte
  assign load_ext = {op_a_sign, op_a_in, `DACC_WORD_RESET}; // [RULE13]

  // plain add is format blind: same bits for integer and fraction
  assign add_ext = cur_acc + load_ext; // [RULE8]

  // selected accumulator for the current operation
  always @* begin
    if (op_acc_sel_in) begin
      cur_acc = acc_two_reg;
    end else begin
      cur_acc = acc_one_reg;
    end
  end

  // pick the raw value before saturation shaping
  always @* begin
    case (op_in)
      `DACC_OP_MPY: raw_value = product_ext;
      `DACC_OP_ADD: raw_value = add_ext;
      `DACC_OP_LOAD: raw_value = load_ext;
      default: raw_value = cur_acc;
    endcase
  end

  dacc_result_fmt #(
    .ACC_W(ACC_W)
  ) u_fmt (
    .value_in(raw_value),
    .guard_en_in(guard_en),
    .result_out(fmt_value)
  );

  // register write decode; select codes 6 and 7 match nothing and are ignored
  assign wr_one_low = reg_wr_in & (reg_sel_in == `DACC_SEL_A_LOW); // [RULE16]
  assign wr_one_high = reg_wr_in & (reg_sel_in == `DACC_SEL_A_HIGH); // [RULE16]
  assign wr_one_upper = reg_wr_in & (reg_sel_in == `DACC_SEL_A_UPPER); // [RULE16]
  assign wr_two_low = reg_wr_in & (reg_sel_in == `DACC_SEL_B_LOW); // [RULE16]
  assign wr_two_high = reg_wr_in & (reg_sel_in == `DACC_SEL_B_HIGH); // [RULE16]
  assign wr_two_upper = reg_wr_in & (reg_sel_in == `DACC_SEL_B_UPPER); // [RULE16]

  // accumulator one by parts; a same-cycle operation beats a register write
  always @* begin
    one_low_next = acc_one_reg[`DACC_LOW_MSB:`DACC_LOW_LSB];
    one_high_next = acc_one_reg[`DACC_HIGH_MSB:`DACC_HIGH_LSB];
    one_guard_next = acc_one_reg[`DACC_GUARD_MSB:`DACC_GUARD_LSB];
    if (wr_one_low) begin
      one_low_next = reg_wdata_in;
    end
    if (wr_one_high) begin
      one_high_next = reg_wdata_in;
    end
    // only the low byte of a write reaches the guard byte
    if (wr_one_upper) begin
      one_guard_next = reg_wdata_in[`DACC_GUARD_W-1:0];
    end
    // register writes are never saturated, operation results already are when guard mode is off
    if (op_to_one) begin
      one_low_next = fmt_value[`DACC_LOW_MSB:`DACC_LOW_LSB]; // [RULE4] [RULE15]
      one_high_next = fmt_value[`DACC_HIGH_MSB:`DACC_HIGH_LSB]; // [RULE4] [RULE15]
      one_guard_next = fmt_value[`DACC_GUARD_MSB:`DACC_GUARD_LSB]; // [RULE4] [RULE15]
    end
  end

  // accumulator two by parts; a same-cycle operation beats a register write
  always @* begin
    two_low_next = acc_two_reg[`DACC_LOW_MSB:`DACC_LOW_LSB];
    two_high_next = acc_two_reg[`DACC_HIGH_MSB:`DACC_HIGH_LSB];
    two_guard_next = acc_two_reg[`DACC_GUARD_MSB:`DACC_GUARD_LSB];
    if (wr_two_low) begin
      two_low_next = reg_wdata_in;
    end
    if (wr_two_high) begin
      two_high_next = reg_wdata_in;
    end
    // only the low byte of a write reaches the guard byte
    if (wr_two_upper) begin
      two_guard_next = reg_wdata_in[`DACC_GUARD_W-1:0];
    end
    // register writes are never saturated, operation results already are when guard mode is off
    if (op_to_two) begin
      two_low_next = fmt_value[`DACC_LOW_MSB:`DACC_LOW_LSB]; // [RULE4] [RULE15]
      two_high_next = fmt_value[`DACC_HIGH_MSB:`DACC_HIGH_LSB]; // [RULE4] [RULE15]
      two_guard_next = fmt_value[`DACC_GUARD_MSB:`DACC_GUARD_LSB]; // [RULE4] [RULE15]
    end
  end

  // the 40-bit word is guard byte, high word and low word, top to bottom
  always @* begin
    acc_one_next = {one_guard_next, one_high_next, one_low_next}; // [RULE12]
    acc_two_next = {two_guard_next, two_high_next, two_low_next}; // [RULE12]
  end

  // stored sign of each accumulator
  assign one_sign = acc_one_reg[ACC_W-1];
  assign two_sign = acc_two_reg[ACC_W-1];

  // guard bytes read back sign-extended so byte and word reads agree
  assign one_upper_view = {{`DACC_GUARD_W{one_sign}},
    acc_one_reg[`DACC_GUARD_MSB:`DACC_GUARD_LSB]}; // [RULE17]
  assign two_upper_view = {{`DACC_GUARD_W{two_sign}},
    acc_two_reg[`DACC_GUARD_MSB:`DACC_GUARD_LSB]}; // [RULE17]

  // read mux on this cycle's select; the answer shows one edge later
  always @* begin
    case (reg_sel_in)
      `DACC_SEL_A_LOW: rdata_next = acc_one_reg[`DACC_LOW_MSB:`DACC_LOW_LSB]; // [RULE16]
      `DACC_SEL_A_HIGH: rdata_next = acc_one_reg[`DACC_HIGH_MSB:`DACC_HIGH_LSB]; // [RULE16]
      `DACC_SEL_A_UPPER: rdata_next = one_upper_view; // [RULE17]
      `DACC_SEL_B_LOW: rdata_next = acc_two_reg[`DACC_LOW_MSB:`DACC_LOW_LSB]; // [RULE16]
      `DACC_SEL_B_HIGH: rdata_next = acc_two_reg[`DACC_HIGH_MSB:`DACC_HIGH_LSB]; // [RULE16]
      `DACC_SEL_B_UPPER: rdata_next = two_upper_view; // [RULE17]
      default: rdata_next = `DACC_WORD_RESET;
    endcase
  end

  // store takes the high word, which keeps it on the 16-bit bus; data holds until the next store
  always @* begin
    store_data_next = store_data_out;
    if (store_in) begin
      if (store_acc_sel_in) begin
        store_data_next = acc_two_reg[`DACC_HIGH_MSB:`DACC_HIGH_LSB]; // [RULE14]
      end else begin
        store_data_next = acc_one_reg[`DACC_HIGH_MSB:`DACC_HIGH_LSB]; // [RULE14]
      end
    end
  end

  // store strobe delayed one edge so the output comes from a flop
  assign store_valid_next = store_in;

  // guard flag mirrored one edge late, for software to see the active width
  assign guard_mode_next = guard_en; // [RULE5]

  // accumulator one storage
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      acc_one_reg <= `DACC_ACC_RESET;
    end else begin
      acc_one_reg <= acc_one_next;
    end
  end

  // accumulator two storage
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      acc_two_reg <= `DACC_ACC_RESET;
    end else begin
      acc_two_reg <= acc_two_next;
    end
  end

  // registered read data
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= `DACC_WORD_RESET;
    end else begin
      reg_rdata_out <= rdata_next;
    end
  end

  // registered store data, pre-operation value of the storing edge
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      store_data_out <= `DACC_WORD_RESET;
    end else begin
      store_data_out <= store_data_next;
    end
  end

  // one-cycle store strobe
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      store_valid_out <= 1'h0;
    end else begin
      store_valid_out <= store_valid_next;
    end
  end

  // guard mode flag
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      guard_mode_out <= 1'h0;
    end else begin
      guard_mode_out <= guard_mode_next;
    end
  end
endmodule

// ===== tb/dacc_core_model.sv
`timescale 1ns/10ps
// core side: forms the control word the way software programs it
module dacc_core_model (
  input wire int_fmt_in,
  input wire guard_in,
  output wire [15:0] core_control_reg_out
);
  // only format and guard bits set; other control bits stay clear so nothing else moves
  assign core_control_reg_out = {11'h000, guard_in, 3'h0, int_fmt_in};
endmodule

// ===== tb/dacc_datapath_asserts.sv
`timescale 1ns/10ps
module dacc_datapath_asserts (
  input wire clock_in,
  input wire reset_in,
  input wire [15:0] core_control_reg_in,
  input wire [1:0] op_in,
  input wire op_acc_sel_in,
  input wire [15:0] op_a_in,
  input wire store_in,
  input wire reg_wr_in,
  input wire [2:0] reg_sel_in,
  input wire [15:0] reg_rdata_out,
  input wire [15:0] store_data_out,
  input wire store_valid_out,
  input wire guard_mode_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // a load followed by an idle cycle on the same select
  sequence s_load(logic [2:0] k);
    op_in == 2'h1 && !op_acc_sel_in && reg_sel_in == k ##1 op_in == 2'h0 && !reg_wr_in && reg_sel_in == k;
  endsequence
  property p_load_low; s_load(3'h0) |=> reg_rdata_out == 16'h0000; endproperty
  a_load_low: assert property (p_load_low) else $error("load low word not zero");
  property p_load_high; s_load(3'h1) |=> reg_rdata_out == $past(op_a_in, 2); endproperty
  a_load_high: assert property (p_load_high) else $error("load high word wrong");
  property p_load_upper; s_load(3'h2) |=> reg_rdata_out == {16{$past(op_a_in[15], 2)}}; endproperty
  a_load_upper: assert property (p_load_upper) else $error("load upper not sign");
  property p_unmapped; reg_sel_in > 3'h5 |=> reg_rdata_out == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_upper_sext; (reg_sel_in == 3'h2 || reg_sel_in == 3'h5) |=> reg_rdata_out[15:8] == {8{reg_rdata_out[7]}};
  endproperty
  a_upper_sext: assert property (p_upper_sext) else $error("upper read not extended");
  property p_store_pulse; store_in |=> store_valid_out ##1 ($past(store_in) || !store_valid_out); endproperty
  a_store_pulse: assert property (p_store_pulse) else $error("store valid not one cycle");
  property p_store_hold; !store_in |=> $stable(store_data_out); endproperty
  a_store_hold: assert property (p_store_hold) else $error("store data moved");
  property p_guard; core_control_reg_in[4] |=> guard_mode_out; endproperty
  a_guard: assert property (p_guard) else $error("guard mode not shown");
endmodule
bind dacc_datapath dacc_datapath_asserts u_chk (.clock_in, .reset_in, .core_control_reg_in, .op_in, .op_acc_sel_in,
  .op_a_in, .store_in, .reg_wr_in, .reg_sel_in, .reg_rdata_out, .store_data_out, .store_valid_out, .guard_mode_out);

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic clock_in = 0, reset_in = 1, int_fmt = 0, guard = 0, op_acc_sel_in = 0, store_in = 0, reg_wr_in = 0, s = 0, t;
  logic [1:0] op_in = 0;
  logic [2:0] reg_sel_in = 0;
  logic [15:0] op_a_in = 0, op_b_in = 0, reg_wdata_in = 0, a, b;
  wire [15:0] ccr, rdata, sdata;
  wire svalid, gmode;
  integer n_mismatch = 0, tests_run = 0, cyc = 0, i;
  dacc_core_model u_core (.int_fmt_in(int_fmt), .guard_in(guard), .core_control_reg_out(ccr));
  dacc_datapath u_dut (.clock_in(clock_in), .reset_in(reset_in), .core_control_reg_in(ccr), .op_in(op_in),
    .op_acc_sel_in(op_acc_sel_in), .op_a_in(op_a_in), .op_b_in(op_b_in), .store_in(store_in),
    .store_acc_sel_in(s), .reg_wr_in(reg_wr_in), .reg_sel_in(reg_sel_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(rdata), .store_data_out(sdata), .store_valid_out(svalid), .guard_mode_out(gmode));
  // 40 ns period
  initial forever #20 clock_in = ~clock_in;
  // hang guard, far beyond the few hundred cycles the run needs
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task print_verdict;
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input string nm, input [15:0] ex, input [15:0] got);
    tests_run++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task issue(input [1:0] o, input t, input [15:0] x, input [15:0] y, input [2:0] rs);
    @(posedge clock_in);
    op_in <= o; op_acc_sel_in <= t; op_a_in <= x; op_b_in <= y; reg_sel_in <= rs;
    @(posedge clock_in);
    op_in <= 2'h0;
  endtask
  task wr(input [2:0] rs, input [15:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1; reg_sel_in <= rs; reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 0;
  endtask
  // read data is registered from the previous cycle's select
  task rd(input [2:0] rs, input [15:0] ex);
    @(posedge clock_in);
    reg_sel_in <= rs;
    @(posedge clock_in);
    #1 cmp("read data", ex, rdata);
  endtask
  // sub-register view: low, high, upper read back sign-extended
  function [15:0] part(input [39:0] v, input [1:0] k);
    part = k == 0 ? v[15:0] : k == 1 ? v[31:16] : {{8{v[39]}}, v[39:32]};
  endfunction
  task chk(input t, input [39:0] v);
    for (int k = 0; k < 3; k++) rd((t ? 3'h3 : 3'h0) + k[2:0], part(v, k[1:0]));
  endtask
  // signed 16x16 product, doubled in fractional mode to sit on the 1.31 point
  function [39:0] multiply_to_accum_op(input [15:0] x, input [15:0] y, input f);
    logic signed [31:0] p;
    p = $signed(x) * $signed(y);
    if (!f) p = p <<< 1;
    multiply_to_accum_op = {{8{p[31]}}, p};
  endfunction
  initial begin
    repeat (10) @(posedge clock_in);
    reset_in <= 0;
    i = $urandom(32'h165f);
    for (i = 0; i < 3; i++) begin
      issue(2'h1, 0, 16'h8001, 0, i[2:0]);
      rd(i[2:0], part(40'hFF80010000, i[1:0]));
    end
    for (i = 0; i < 2; i++) begin
      guard <= i[0]; int_fmt <= i[0];
      issue(2'h1, 0, 16'h7FFF, 0, 0); issue(2'h3, 0, 16'h7FFF, 0, 0);
      chk(0, i ? 40'h00FFFE0000 : 40'h007FFFFFFF);
      issue(2'h1, 1, 16'h8000, 0, 0); issue(2'h3, 1, 16'h8000, 0, 0);
      chk(1, i ? 40'hFF00000000 : 40'hFF80000000);
      cmp("guard mode", i[0], {15'h0, gmode});
    end
    for (i = 0; i < 16; i++) begin
      a = i == 0 ? 16'h4000 : i == 1 ? 16'h8000 : $urandom;
      b = i == 0 ? 16'h4000 : i == 1 ? 16'h7FFF : $urandom;
      if (a == 16'h8000 && b == 16'h8000) b = 16'h0001;
      t = $urandom; int_fmt <= i > 1 ? $urandom : 1'b0; guard <= $urandom;
      issue(2'h2, t, a, b, 0);
      chk(t, multiply_to_accum_op(a, b, int_fmt));
    end
    wr(3'h3, a); wr(3'h4, b); wr(3'h5, 16'h1280); wr(3'h6, 16'hFFFF);
    chk(1, {8'h80, b, a});
    rd(3'h6, 16'h0000);
    @(posedge clock_in);
    store_in <= 1; s <= 1;
    @(posedge clock_in);
    store_in <= 0;
    #1 cmp("store valid", 1, {15'h0, svalid});
    cmp("store data", b, sdata);
    @(posedge clock_in);
    #1 cmp("store valid", 0, {15'h0, svalid});
    print_verdict;
  end
endmodule
